// [logic/fer_regs.sv]
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module fer_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwr_good_rst_n,
	input wire logic [fer_pkg::FER_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fer_pkg::FER_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_valid,
	input wire logic [15:0] fault_requester_tag,
	input wire logic [7:0] fault_reason_code,
	input wire logic fault_is_read,
	input wire logic fault_is_intr,
	input wire logic [51:0] fault_page_addr,
	input wire logic [15:0] fault_intr_index,
	output logic msg_wr_valid,
	input wire logic msg_wr_ready,
	output logic [63:0] msg_wr_addr,
	output logic [31:0] msg_wr_data,
	output logic irq
);
	import fer_pkg::*;

	localparam int NR = FER_NUM_REC;
	localparam logic [51:0] PAGE_KEEP = 52'({1'h1, {FER_MAX_GUEST_ADDR_WIDTH{1'h0}}} - 1) >> FER_FI_LO;
	localparam logic [31:0] CAP_WORD = 32'((FER_OFF_REC_BASE / FER_REC_STRIDE) << FER_CAP_OFS_LSB)
		| 32'(NR - 1);

	// ****************************************
	// Storage
	// ****************************************
	logic [31:0] msg_data_reg;
	logic [31:0] msg_addr_reg;
	logic [31:0] msg_uaddr_reg;
	logic [1:0] ctrl_reg;
	logic [FER_ST_W-1:0] status_reg;
	logic [FER_ST_W-1:0] mask_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic msg_pend_reg;

	logic [126:0] rec_body [NR];
	logic [NR-1:0] rec_arm;
	logic [NR-1:0] rec_flag;
	logic [NR-1:0] rec_cap;
	logic [NR-1:0] rec_clr;
	logic [NR-1:0] rec_hit;

	// ****************************************
	// Write channel decode
	// ****************************************
	wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	wire [9:0] wr_dw = s_axi_awaddr[11:2];
	wire wr_sel_data = (wr_dw == FER_OFF_MSG_DATA[11:2]);
	wire wr_sel_addr = (wr_dw == FER_OFF_MSG_ADDR[11:2]);
	wire wr_sel_uaddr = (wr_dw == FER_OFF_MSG_UADDR[11:2]);
	wire wr_sel_ctrl = (wr_dw == FER_OFF_CTRL[11:2]);
	wire wr_sel_status = (wr_dw == FER_OFF_STATUS[11:2]);
	wire wr_sel_mask = (wr_dw == FER_OFF_MASK[11:2]);
	wire wr_sel_cap = (wr_dw == FER_OFF_CAP[11:2]);
	wire wr_sel_rec = (s_axi_awaddr[11:FER_REC_SPAN_LSB] == FER_OFF_REC_BASE[11:FER_REC_SPAN_LSB]);
	wire [FER_REC_IDX_W-1:0] wr_rec_idx = s_axi_awaddr[FER_REC_IDX_LSB +: FER_REC_IDX_W];
	wire [1:0] wr_rec_dw = s_axi_awaddr[FER_REC_DW_LSB +: 2];
	wire wr_mapped = wr_sel_data | wr_sel_addr | wr_sel_uaddr | wr_sel_ctrl | wr_sel_status
		| wr_sel_mask | wr_sel_cap | wr_sel_rec;
	wire wr_flag_clr = wr_fire & wr_sel_rec & (wr_rec_dw == 2'h3) & s_axi_wstrb[3]
		& s_axi_wdata[31];

	function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	wire [31:0] data_merged = strobe_merge(msg_data_reg, s_axi_wdata, s_axi_wstrb);
	wire [31:0] addr_merged = strobe_merge(msg_addr_reg, s_axi_wdata, s_axi_wstrb);
	wire [31:0] uaddr_merged = strobe_merge(msg_uaddr_reg, s_axi_wdata, s_axi_wstrb);
	wire [31:0] data_keep = FER_EXT_DATA_SUP ? 32'hffffffff : 32'h0000ffff;
	wire [31:0] uaddr_keep = FER_EXT_INTR_SUP ? 32'hffffffff : 32'h0;
	wire [FER_ST_W-1:0] st_w1c = (wr_fire & wr_sel_status & s_axi_wstrb[0])
		? s_axi_wdata[FER_ST_W-1:0] : '0;

	// ****************************************
	// Fault capture
	// ****************************************
	wire plog_en = ctrl_reg[FER_CTRL_PLOG];
	wire evt_en = ctrl_reg[FER_CTRL_EVT_EN];
	wire [NR-1:0] rec_used = rec_arm | rec_flag;
	wire tag_hit = |rec_hit;
	wire log_req = fault_valid & plog_en & ~tag_hit;
	wire [51:0] fi_val = fault_is_intr
		? {fault_intr_index, 36'h0}
		: (fault_page_addr & PAGE_KEEP);
	wire [126:0] cap_body = {fault_is_read, 2'h0, 20'h0, fault_reason_code, 16'h0,
		fault_requester_tag, fi_val, 12'h0};
	logic [NR-1:0] free_pick;
	wire no_free = log_req & ~|free_pick;
	wire rec_event = |rec_arm;

	always_comb begin
		free_pick = '0;
		for (int i = NR - 1; i >= 0; i--) begin
			if (!rec_used[i]) begin
				free_pick = NR'(1) << i;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NR; gi++) begin : g_rec
			assign rec_hit[gi] = rec_used[gi]
				& (rec_body[gi][FER_TAG_HI:FER_TAG_LO] == fault_requester_tag);
			assign rec_cap[gi] = log_req & free_pick[gi];
			assign rec_clr[gi] = wr_flag_clr & (wr_rec_idx == FER_REC_IDX_W'(gi));
			fer_record_slot u_slot (
				.mclk(mclk),
				.pwr_good_rst_n(pwr_good_rst_n),
				.cap_en(rec_cap[gi]),
				.cap_body(cap_body),
				.clr_flag(rec_clr[gi]),
				.body(rec_body[gi]),
				.arm(rec_arm[gi]),
				.flag(rec_flag[gi])
			);
		end
	endgenerate

	// ****************************************
	// Read channel decode
	// ****************************************
	wire ar_fire = s_axi_arvalid & ~rvalid_reg;
	wire [9:0] rd_dw = s_axi_araddr[11:2];
	wire rd_sel_rec = (s_axi_araddr[11:FER_REC_SPAN_LSB] == FER_OFF_REC_BASE[11:FER_REC_SPAN_LSB]);
	wire [FER_REC_IDX_W-1:0] rd_rec_idx = s_axi_araddr[FER_REC_IDX_LSB +: FER_REC_IDX_W];
	wire [1:0] rd_rec_dw = s_axi_araddr[FER_REC_DW_LSB +: 2];
	wire [127:0] rd_rec = {rec_flag[rd_rec_idx], rec_body[rd_rec_idx]};
	wire [31:0] rd_rec_word = rd_rec[32*rd_rec_dw +: 32];
	logic [31:0] rd_word;
	logic rd_ok;

	always_comb begin
		rd_ok = 1'h1;
		case (rd_dw)
			FER_OFF_CAP[11:2]: rd_word = CAP_WORD;
			FER_OFF_STATUS[11:2]: rd_word = 32'(status_reg);
			FER_OFF_MASK[11:2]: rd_word = 32'(mask_reg);
			FER_OFF_CTRL[11:2]: rd_word = 32'(ctrl_reg);
			FER_OFF_MSG_DATA[11:2]: rd_word = msg_data_reg;
			FER_OFF_MSG_ADDR[11:2]: rd_word = msg_addr_reg;
			FER_OFF_MSG_UADDR[11:2]: rd_word = msg_uaddr_reg;
			default: begin
				rd_word = rd_sel_rec ? rd_rec_word : FER_RST_WORD;
				rd_ok = rd_sel_rec;
			end
		endcase
	end

	// ****************************************
	// Register updates
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			msg_data_reg <= FER_RST_WORD;
			msg_addr_reg <= FER_RST_WORD;
			msg_uaddr_reg <= FER_RST_WORD;
			ctrl_reg <= '0;
			mask_reg <= '0;
		end else if (wr_fire) begin
			if (wr_sel_data) begin
				msg_data_reg <= data_merged & data_keep;
			end
			if (wr_sel_addr) begin
				msg_addr_reg <= {addr_merged[31:2], 2'h0};
			end
			if (wr_sel_uaddr) begin
				msg_uaddr_reg <= uaddr_merged & uaddr_keep;
			end
			if (wr_sel_ctrl && s_axi_wstrb[0]) begin
				ctrl_reg <= s_axi_wdata[1:0];
			end
			if (wr_sel_mask && s_axi_wstrb[0]) begin
				mask_reg <= s_axi_wdata[FER_ST_W-1:0];
			end
		end
	end

	// Sticky events: a new event in the clearing cycle survives the clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~st_w1c) | {no_free, rec_event};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'h0;
			bresp_reg <= FER_RESP_OKAY;
			rvalid_reg <= 1'h0;
			rresp_reg <= FER_RESP_OKAY;
			rdata_reg <= FER_RST_WORD;
		end else begin
			if (wr_fire) begin
				bvalid_reg <= 1'h1;
				bresp_reg <= wr_mapped ? FER_RESP_OKAY : FER_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'h0;
			end
			if (ar_fire) begin
				rvalid_reg <= 1'h1;
				rresp_reg <= rd_ok ? FER_RESP_OKAY : FER_RESP_SLVERR;
				rdata_reg <= rd_word;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'h0;
			end
		end
	end

	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign irq = |(status_reg & mask_reg);

	// ****************************************
	// Fault event message
	// ****************************************
	logic mw_busy;
	// One message is kept pending; further events while pending fold into it
	wire msg_fire = msg_pend_reg & evt_en & ~mw_busy;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			msg_pend_reg <= 1'h0;
		end else begin
			msg_pend_reg <= (msg_pend_reg & ~msg_fire) | (rec_event & evt_en);
		end
	end

	fer_msg_writer u_msg (
		.mclk(mclk),
		.rst_n(rst_n),
		.fire(msg_fire),
		.addr_low(msg_addr_reg),
		.addr_high(msg_uaddr_reg),
		.data(msg_data_reg),
		.busy(mw_busy),
		.msg_wr_valid(msg_wr_valid),
		.msg_wr_ready(msg_wr_ready),
		.msg_wr_addr(msg_wr_addr),
		.msg_wr_data(msg_wr_data)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n || !pwr_good_rst_n);

	data_write_a: assert property (
		wr_fire && wr_sel_data && s_axi_wstrb == 4'hf |=> msg_data_reg == $past(s_axi_wdata))
		else $error("message data not stored");
	addr_low_zero_a: assert property (msg_addr_reg[1:0] == 2'h0)
		else $error("message address low bits not zero");
	upper_addr_a: assert property (
		wr_fire && wr_sel_uaddr && s_axi_wstrb == 4'hf |=> msg_uaddr_reg == $past(s_axi_wdata))
		else $error("upper address not stored");
	no_log_off_a: assert property (fault_valid && !plog_en |=> rec_arm == '0)
		else $error("record filled while logging off");
	cap_read_a: assert property (
		ar_fire && rd_dw == FER_OFF_CAP[11:2] |=> s_axi_rdata == CAP_WORD)
		else $error("capability word wrong");
	flag_after_body_a: assert property (
		$rose(rec_flag[0]) |-> $past(rec_arm[0]) && !$past(rec_cap[0]))
		else $error("flag set before details");
	merge_a: assert property (fault_valid && plog_en && tag_hit |=> rec_arm == '0)
		else $error("same requester logged twice");
	flag_clear_a: assert property (rec_clr[0] && !rec_arm[0] |=> !rec_flag[0])
		else $error("flag not cleared by write one");
	capture_fields_a: assert property (rec_cap[0] |=>
		rec_body[0][FER_T_BIT] == $past(fault_is_read)
		&& rec_body[0][FER_TAG_HI:FER_TAG_LO] == $past(fault_requester_tag)
		&& rec_body[0][FER_FR_HI:FER_FR_LO] == $past(fault_reason_code))
		else $error("record fields not captured");
	page_bound_a: assert property (rec_cap[0] && !fault_is_intr |=>
		rec_body[0][FER_FI_HI:FER_MAX_GUEST_ADDR_WIDTH] == '0)
		else $error("page address above guest width");
	intr_info_a: assert property (rec_cap[0] && fault_is_intr |=>
		rec_body[0][FER_IDX_LO-1:FER_FI_LO] == '0
		&& rec_body[0][FER_FI_HI:FER_IDX_LO] == $past(fault_intr_index))
		else $error("interrupt index record wrong");
	msg_launch_a: assert property (msg_fire |=> msg_wr_valid
		&& msg_wr_addr == {$past(msg_uaddr_reg), $past(msg_addr_reg)}
		&& msg_wr_data == $past(msg_data_reg))
		else $error("message write wrong");

	log_cover_c: cover property (rec_cap[0] ##2 rec_flag[0]);
	merge_cover_c: cover property (fault_valid && plog_en && tag_hit);
	msg_cover_c: cover property (msg_wr_valid && msg_wr_ready);
	ovf_cover_c: cover property (no_free);
endmodule
`default_nettype wire

// [logic/fer_pkg.sv]
`default_nettype none
package fer_pkg;
	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int FER_ADDR_W = 12;
	localparam logic [1:0] FER_RESP_OKAY = 2'h0;
	localparam logic [1:0] FER_RESP_SLVERR = 2'h2;
	localparam logic [31:0] FER_RST_WORD = 32'h0;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] FER_OFF_CAP = 12'h010;
	localparam logic [11:0] FER_OFF_STATUS = 12'h020;
	localparam logic [11:0] FER_OFF_MASK = 12'h024;
	localparam logic [11:0] FER_OFF_CTRL = 12'h028;
	localparam logic [11:0] FER_OFF_MSG_DATA = 12'h03c;
	localparam logic [11:0] FER_OFF_MSG_ADDR = 12'h040;
	localparam logic [11:0] FER_OFF_MSG_UADDR = 12'h044;
	localparam logic [11:0] FER_OFF_REC_BASE = 12'h200;

	// ****************************************
	// Record layout
	// ****************************************
	localparam int FER_NUM_REC = 4;
	localparam int FER_REC_IDX_W = 2;
	localparam int FER_REC_IDX_LSB = 4;
	localparam int FER_REC_DW_LSB = 2;
	localparam int FER_REC_SPAN_LSB = 6;
	localparam int FER_REC_STRIDE = 16;
	localparam int FER_F_BIT = 127;
	localparam int FER_T_BIT = 126;
	localparam int FER_FR_HI = 103;
	localparam int FER_FR_LO = 96;
	localparam int FER_TAG_HI = 79;
	localparam int FER_TAG_LO = 64;
	localparam int FER_FI_HI = 63;
	localparam int FER_FI_LO = 12;
	localparam int FER_IDX_LO = 48;
	localparam int FER_MAX_GUEST_ADDR_WIDTH = 48;
	localparam logic FER_EXT_DATA_SUP = 1'h1;
	localparam logic FER_EXT_INTR_SUP = 1'h1;

	// ****************************************
	// Control, status and capability fields
	// ****************************************
	localparam int FER_CTRL_EVT_EN = 0;
	localparam int FER_CTRL_PLOG = 1;
	localparam int FER_ST_LOGGED = 0;
	localparam int FER_ST_OVF = 1;
	localparam int FER_ST_W = 2;
	localparam int FER_CAP_OFS_LSB = 8;

	typedef enum logic [1:0] {
		FER_MW_IDLE = 2'h1,
		FER_MW_SEND = 2'h2
	} fer_mw_state_t;
endpackage
`default_nettype wire

// [logic/fer_record_slot.sv]
`timescale 1ns/100ps
`default_nettype none
module fer_record_slot (
	input wire logic mclk,
	input wire logic pwr_good_rst_n,
	input wire logic cap_en,
	input wire logic [126:0] cap_body,
	input wire logic clr_flag,
	output logic [126:0] body,
	output logic arm,
	output logic flag
);
	import fer_pkg::*;

	logic [126:0] body_reg;
	logic arm_reg;
	logic flag_reg;

	// Only power-good reset touches the record; it is sticky otherwise
	always_ff @(posedge mclk or negedge pwr_good_rst_n) begin
		if (!pwr_good_rst_n) begin
			body_reg <= '0;
			arm_reg <= 1'h0;
			flag_reg <= 1'h0;
		end else begin
			if (cap_en) begin
				body_reg <= cap_body;
			end
			arm_reg <= cap_en;
			// Flag rises one edge after the details land; setting beats clearing
			if (arm_reg) begin
				flag_reg <= 1'h1;
			end else if (clr_flag) begin
				flag_reg <= 1'h0;
			end
		end
	end

	assign body = body_reg;
	assign arm = arm_reg;
	assign flag = flag_reg;
endmodule
`default_nettype wire

// [logic/fer_msg_writer.sv]
`timescale 1ns/100ps
`default_nettype none
module fer_msg_writer (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic [31:0] addr_low,
	input wire logic [31:0] addr_high,
	input wire logic [31:0] data,
	output logic busy,
	output logic msg_wr_valid,
	input wire logic msg_wr_ready,
	output logic [63:0] msg_wr_addr,
	output logic [31:0] msg_wr_data
);
	import fer_pkg::*;

	fer_mw_state_t state_reg;
	fer_mw_state_t state_next;
	logic [63:0] addr_reg;
	logic [31:0] data_reg;

	always_comb begin
		case (state_reg)
			FER_MW_IDLE: state_next = fire ? FER_MW_SEND : FER_MW_IDLE;
			FER_MW_SEND: state_next = msg_wr_ready ? FER_MW_IDLE : FER_MW_SEND;
			default: state_next = FER_MW_IDLE;
		endcase
	end

	// Address and payload are frozen at launch so software rewrites cannot tear a message
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= FER_MW_IDLE;
			addr_reg <= '0;
			data_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (fire && state_reg == FER_MW_IDLE) begin
				addr_reg <= {addr_high, addr_low};
				data_reg <= data;
			end
		end
	end

	assign busy = (state_reg != FER_MW_IDLE);
	assign msg_wr_valid = (state_reg == FER_MW_SEND);
	assign msg_wr_addr = addr_reg;
	assign msg_wr_data = data_reg;
endmodule
`default_nettype wire

// [sim/fer_msg_sink.sv]
`timescale 1ns/100ps
`default_nettype none
module fer_msg_sink (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic msg_wr_valid,
	output logic msg_wr_ready,
	input wire logic [63:0] msg_wr_addr,
	input wire logic [31:0] msg_wr_data,
	output logic [7:0] got_cnt,
	output logic [63:0] got_addr,
	output logic [31:0] got_data
);
	logic [3:0] wait_reg;

	// Slow mode holds ready off for a few cycles to prove the writer holds its offer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			msg_wr_ready <= 1'b0;
			wait_reg <= 4'h0;
			got_cnt <= 8'h0;
			got_addr <= 64'h0;
			got_data <= 32'h0;
		end else if (msg_wr_valid && msg_wr_ready) begin
			got_cnt <= got_cnt + 8'h1;
			got_addr <= msg_wr_addr;
			got_data <= msg_wr_data;
			msg_wr_ready <= 1'b0;
			wait_reg <= 4'h0;
		end else if (msg_wr_valid) begin
			msg_wr_ready <= (wait_reg >= (slow ? 4'h3 : 4'h0));
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import fer_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic pwr_good_rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic fault_valid = 1'b0;
	logic [15:0] fault_requester_tag = 16'h0;
	logic [7:0] fault_reason_code = 8'h0;
	logic fault_is_read = 1'b0;
	logic fault_is_intr = 1'b0;
	logic [51:0] fault_page_addr = 52'h0;
	logic [15:0] fault_intr_index = 16'h0;
	logic slow = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, msg_wr_data, got_data;
	logic msg_wr_valid, msg_wr_ready, irq;
	logic [63:0] msg_wr_addr, got_addr;
	logic [7:0] got_cnt;
	logic [31:0] d;
	int n_errors = 0;
	int compares = 0;

	fer_regs uut (.mclk(mclk), .rst_n(rst_n), .pwr_good_rst_n(pwr_good_rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .fault_valid(fault_valid),
		.fault_requester_tag(fault_requester_tag), .fault_reason_code(fault_reason_code),
		.fault_is_read(fault_is_read), .fault_is_intr(fault_is_intr),
		.fault_page_addr(fault_page_addr), .fault_intr_index(fault_intr_index),
		.msg_wr_valid(msg_wr_valid), .msg_wr_ready(msg_wr_ready),
		.msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data), .irq(irq));

	fer_msg_sink sink (.mclk(mclk), .rst_n(rst_n), .slow(slow), .msg_wr_valid(msg_wr_valid),
		.msg_wr_ready(msg_wr_ready), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data),
		.got_cnt(got_cnt), .got_addr(got_addr), .got_data(got_data));

	always #25 mclk = ~mclk;

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [11:0] rec(input int n, input int k);
		return FER_OFF_REC_BASE + 12'(16 * n + 4 * k);
	endfunction

	// Payload is held until its own ready; bready stays up until bvalid is seen
	task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(t, 32'h2);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic axr(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
		int t;
		t = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		chk(t, 32'h2);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic flt(input logic [15:0] tg, input logic [7:0] rc, input logic rd,
		input logic intr, input logic [51:0] pg, input logic [15:0] ix);
		@(posedge mclk);
		fault_requester_tag <= tg;
		fault_reason_code <= rc;
		fault_is_read <= rd;
		fault_is_intr <= intr;
		fault_page_addr <= pg;
		fault_intr_index <= ix;
		fault_valid <= 1'b1;
		@(posedge mclk);
		fault_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic wait_msg(input logic [7:0] n);
		int t;
		t = 0;
		while (got_cnt !== n && t < 40) begin
			@(posedge mclk);
			t++;
		end
		chk({24'h0, got_cnt}, {24'h0, n});
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		pwr_good_rst_n <= 1'b1;
		axr(FER_OFF_MSG_DATA, FER_RESP_OKAY, d);
		chk(d, 32'h0);
		axr(FER_OFF_MSG_ADDR, FER_RESP_OKAY, d);
		chk(d, 32'h0);
		axr(FER_OFF_MSG_UADDR, FER_RESP_OKAY, d);
		chk(d, 32'h0);
		axw(FER_OFF_MSG_DATA, 32'hffffffff, FER_RESP_OKAY);
		axw(FER_OFF_MSG_ADDR, 32'hffffffff, FER_RESP_OKAY);
		axw(FER_OFF_MSG_UADDR, 32'hffffffff, FER_RESP_OKAY);
		axr(FER_OFF_MSG_DATA, FER_RESP_OKAY, d);
		chk(d, 32'hffffffff);
		axr(FER_OFF_MSG_ADDR, FER_RESP_OKAY, d);
		chk(d, 32'hfffffffc);
		axr(FER_OFF_MSG_UADDR, FER_RESP_OKAY, d);
		chk(d, 32'hffffffff);
		axr(FER_OFF_CAP, FER_RESP_OKAY, d);
		chk(d & 32'h3ffff, 32'h2003);
		axw(12'h100, 32'h1, FER_RESP_SLVERR);
		axr(12'h100, FER_RESP_SLVERR, d);
		chk(d, 32'h0);
		// Logging off: a fault must leave record 0 empty and send nothing
		flt(16'h1234, 8'h05, 1'b1, 1'b0, 52'h123456789abcd, 16'h0);
		axr(rec(0, 3), FER_RESP_OKAY, d);
		chk(d, 32'h0);
		chk({24'h0, got_cnt}, 32'h0);
		axw(FER_OFF_MSG_DATA, 32'hcafe0123, FER_RESP_OKAY);
		axw(FER_OFF_MSG_ADDR, 32'hfee0100f, FER_RESP_OKAY);
		axw(FER_OFF_MSG_UADDR, 32'h00000012, FER_RESP_OKAY);
		axw(FER_OFF_MASK, 32'h0, FER_RESP_OKAY);
		axw(FER_OFF_CTRL, 32'h3, FER_RESP_OKAY);
		slow <= 1'b1;
		flt(16'h1234, 8'h05, 1'b1, 1'b0, 52'h123456789abcd, 16'h0);
		wait_msg(8'h1);
		chk(got_addr[63:32], 32'h00000012);
		chk(got_addr[31:0], 32'hfee0100c);
		chk(got_data, 32'hcafe0123);
		axr(rec(0, 0), FER_RESP_OKAY, d);
		chk(d, 32'h9abcd000);
		axr(rec(0, 1), FER_RESP_OKAY, d);
		chk(d, 32'h00005678);
		axr(rec(0, 2), FER_RESP_OKAY, d);
		chk(d, 32'h00001234);
		axr(rec(0, 3), FER_RESP_OKAY, d);
		chk(d, 32'hc0000005);
		chk({31'h0, irq}, 32'h0);
		axw(FER_OFF_MASK, 32'h1, FER_RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		axw(FER_OFF_STATUS, 32'h1, FER_RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		// Same requester while its record is flagged: merged, record 1 stays free
		flt(16'h1234, 8'h07, 1'b0, 1'b0, 52'h1, 16'h0);
		axr(rec(1, 3), FER_RESP_OKAY, d);
		chk(d, 32'h0);
		slow <= 1'b0;
		flt(16'h00a5, 8'h22, 1'b0, 1'b1, 52'hfffffffffffff, 16'hbeef);
		axr(rec(1, 0), FER_RESP_OKAY, d);
		chk(d, 32'h0);
		axr(rec(1, 1), FER_RESP_OKAY, d);
		chk(d, 32'hbeef0000);
		axr(rec(1, 2), FER_RESP_OKAY, d);
		chk(d, 32'h000000a5);
		axr(rec(1, 3), FER_RESP_OKAY, d);
		chk(d, 32'h80000022);
		axw(rec(0, 3), 32'h0, FER_RESP_OKAY);
		axr(rec(0, 3), FER_RESP_OKAY, d);
		chk(d & 32'h80000000, 32'h80000000);
		axw(rec(0, 3), 32'h80000000, FER_RESP_OKAY);
		axr(rec(0, 3), FER_RESP_OKAY, d);
		chk(d & 32'h80000000, 32'h0);
		// Bus reset alone must not disturb records
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		axr(rec(1, 1), FER_RESP_OKAY, d);
		chk(d, 32'hbeef0000);
		axr(FER_OFF_MSG_DATA, FER_RESP_OKAY, d);
		chk(d, 32'h0);
		// Only byte 0 is enabled, so the other bytes keep their cleared value
		s_axi_wstrb <= 4'h1;
		axw(FER_OFF_MSG_DATA, 32'h12345678, FER_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axr(FER_OFF_MSG_DATA, FER_RESP_OKAY, d);
		chk(d, 32'h00000078);
		@(posedge mclk);
		pwr_good_rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		pwr_good_rst_n <= 1'b1;
		axr(rec(1, 3), FER_RESP_OKAY, d);
		chk(d, 32'h0);
		// Records fill in order; the fifth fault finds none free, and no message leaves
		axw(FER_OFF_CTRL, 32'h2, FER_RESP_OKAY);
		for (int i = 1; i <= 5; i++) begin
			flt(16'(i), 8'h01, 1'b0, i == 1, 52'h0, 16'h00c3);
		end
		axr(rec(0, 1), FER_RESP_OKAY, d);
		chk(d, 32'h00c30000);
		axr(rec(3, 2), FER_RESP_OKAY, d);
		chk(d, 32'h4);
		axr(FER_OFF_STATUS, FER_RESP_OKAY, d);
		chk(d, 32'h3);
		chk({24'h0, got_cnt}, 32'h0);
		axw(FER_OFF_MASK, 32'h2, FER_RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		end_sim();
	end

	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
